// ===== rtl/spd_dividers.sv
// Digital core of a serially programmed PLL synthesizer: serial load port,
// reference divider, pulse-swallow feedback divider and phase detector.
// Assumes every input but the asynchronous rstn is synchronous to clk and that the reference and RF
// inputs toggle well below half the clock rate (edges are found by sampling).
`default_nettype none

module spd_dividers
(
	// System
	input wire logic clk,
	input wire logic rstn,
	// Serial load port
	input wire logic serialClk,
	input wire logic serialData,
	input wire logic loadStrobe,
	// Divider inputs
	input wire logic refOsc,
	input wire logic rfIn,
	// Phase sense
	input wire logic phaseSenseSelect,
	// Divided clocks and monitor
	output logic refSidePulse,
	output logic vcoSidePulse,
	output logic dividerMonitorPin,
	// Charge pump drive
	output logic pumpUp,
	output logic pumpDown,
	output logic extPumpUpN,
	output logic extPumpDownN
);

	spd_pkg::spd_state_t s;
	spd_pkg::spd_state_t nxt_s;
	logic sclkRise;
	logic loadRise;
	logic oscRise;
	logic rfRise;
	logic refFire;
	logic vcoFire;
	logic preTick;
	logic leadEdge;
	logic lagEdge;
	logic bothPulse;
	logic [spd_pkg::PRE_W-1:0] modulus;

	assign sclkRise = serialClk & ~s.sclkPrev;
	assign loadRise = loadStrobe & ~s.loadPrev;
	assign oscRise = refOsc & ~s.oscPrev;
	assign rfRise = rfIn & ~s.rfPrev;
	assign modulus = spd_pkg::preModulus(s.prescalerPickBit,
		s.swallowLeft != '0);

	// --------------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------------
	always_comb
	begin
		nxt_s = s;
		nxt_s.sclkPrev = serialClk;
		nxt_s.loadPrev = loadStrobe;
		nxt_s.oscPrev = refOsc;
		nxt_s.rfPrev = rfIn;

		if (sclkRise)
		begin
			nxt_s.shiftReg = {s.shiftReg[spd_pkg::WORD_W-2:0], serialData};
		end

		// Latches change only on the strobe, so a word half shifted in
		// never disturbs the running dividers
		if (loadRise)
		begin
			if (s.shiftReg[spd_pkg::STEER_BIT])
			begin
				nxt_s.refRatio = s.shiftReg[spd_pkg::REF_MSB:spd_pkg::REF_LSB];
				nxt_s.prescalerPickBit = s.shiftReg[spd_pkg::PICK_BIT];
			end
			else
			begin
				nxt_s.swallowRatio = s.shiftReg[spd_pkg::SWAL_MSB:spd_pkg::SWAL_LSB];
				nxt_s.progRatio = s.shiftReg[spd_pkg::PROG_MSB:spd_pkg::PROG_LSB];
			end
		end

		// ----------------------------------------------------------------
		// Reference divider
		// ----------------------------------------------------------------
		// Compare with >= so a smaller new ratio cannot strand the count
		refFire = oscRise &&
			(s.refCnt >= s.refRatio - {{(spd_pkg::REF_W-1){1'b0}}, 1'b1});
		if (refFire)
		begin
			nxt_s.refCnt = '0;
		end
		else if (oscRise)
		begin
			nxt_s.refCnt = s.refCnt + {{(spd_pkg::REF_W-1){1'b0}}, 1'b1};
		end

		// ----------------------------------------------------------------
		// Pulse-swallow feedback divider
		// ----------------------------------------------------------------
		preTick = rfRise &&
			(s.preCnt >= modulus - {{(spd_pkg::PRE_W-1){1'b0}}, 1'b1});
		vcoFire = preTick &&
			(s.progLeft <= {{(spd_pkg::PROG_W-1){1'b0}}, 1'b1});
		if (preTick)
		begin
			nxt_s.preCnt = '0;
		end
		else if (rfRise)
		begin
			nxt_s.preCnt = s.preCnt + {{(spd_pkg::PRE_W-1){1'b0}}, 1'b1};
		end
		if (vcoFire)
		begin
			nxt_s.progLeft = s.progRatio;
			nxt_s.swallowLeft = s.swallowRatio;
		end
		else if (preTick)
		begin
			nxt_s.progLeft = s.progLeft - {{(spd_pkg::PROG_W-1){1'b0}}, 1'b1};
			if (s.swallowLeft != '0)
			begin
				nxt_s.swallowLeft = s.swallowLeft -
					{{(spd_pkg::SWAL_W-1){1'b0}}, 1'b1};
			end
		end

		// ----------------------------------------------------------------
		// Phase detector
		// ----------------------------------------------------------------
		// Sense low swaps the roles of the two edges, turning up into down
		leadEdge = phaseSenseSelect ? refFire : vcoFire;
		lagEdge = phaseSenseSelect ? vcoFire : refFire;
		bothPulse = 1'b0;
		unique case (s.pfd)
			spd_pkg::PFD_IDLE:
			begin
				if (leadEdge && lagEdge)
				begin
					bothPulse = 1'b1;
				end
				else if (leadEdge)
				begin
					nxt_s.pfd = spd_pkg::PFD_UP;
				end
				else if (lagEdge)
				begin
					nxt_s.pfd = spd_pkg::PFD_DOWN;
				end
			end
			// Repeated edges of the leading side saturate: two pi range
			spd_pkg::PFD_UP:
			begin
				if (lagEdge)
				begin
					nxt_s.pfd = spd_pkg::PFD_IDLE;
				end
			end
			spd_pkg::PFD_DOWN:
			begin
				if (leadEdge)
				begin
					nxt_s.pfd = spd_pkg::PFD_IDLE;
				end
			end
			default:
			begin
				nxt_s.pfd = spd_pkg::PFD_IDLE;
			end
		endcase
		nxt_s.pumpUp = (nxt_s.pfd == spd_pkg::PFD_UP) || bothPulse;
		nxt_s.pumpDown = (nxt_s.pfd == spd_pkg::PFD_DOWN) || bothPulse;
		nxt_s.extUpN = ~nxt_s.pumpUp;
		nxt_s.extDownN = ~nxt_s.pumpDown;

		nxt_s.refSidePulse = refFire;
		nxt_s.vcoSidePulse = vcoFire;
		nxt_s.monitor = phaseSenseSelect ? refFire : vcoFire;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s <= spd_pkg::RST_STATE;
		end
		else
		begin
			s <= nxt_s;
		end
	end

	assign refSidePulse = s.refSidePulse;
	assign vcoSidePulse = s.vcoSidePulse;
	assign dividerMonitorPin = s.monitor;
	assign pumpUp = s.pumpUp;
	assign pumpDown = s.pumpDown;
	assign extPumpUpN = s.extUpN;
	assign extPumpDownN = s.extDownN;

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_shift_in;
		sclkRise |=> s.shiftReg ==
			{$past(s.shiftReg[spd_pkg::WORD_W-2:0]), $past(serialData)};
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("shift register did not take the serial bit");

	property p_ref_load;
		loadRise && s.shiftReg[spd_pkg::STEER_BIT] |=>
			s.refRatio == $past(s.shiftReg[spd_pkg::REF_MSB:spd_pkg::REF_LSB])
			&& s.prescalerPickBit == $past(s.shiftReg[spd_pkg::PICK_BIT])
			&& $stable(s.progRatio) && $stable(s.swallowRatio);
	endproperty
	a_ref_load: assert property (p_ref_load)
		else $error("reference word loaded wrongly");

	property p_div_load;
		loadRise && !s.shiftReg[spd_pkg::STEER_BIT] |=>
			s.progRatio == $past(s.shiftReg[spd_pkg::PROG_MSB:spd_pkg::PROG_LSB])
			&& s.swallowRatio ==
				$past(s.shiftReg[spd_pkg::SWAL_MSB:spd_pkg::SWAL_LSB])
			&& $stable(s.refRatio) && $stable(s.prescalerPickBit);
	endproperty
	a_div_load: assert property (p_div_load)
		else $error("divider word loaded wrongly");

	property p_no_strobe_hold;
		!loadRise |=> $stable(s.refRatio) && $stable(s.progRatio)
			&& $stable(s.swallowRatio) && $stable(s.prescalerPickBit);
	endproperty
	a_no_strobe_hold: assert property (p_no_strobe_hold)
		else $error("latch changed without a load strobe");

	property p_modulus;
		modulus == (s.prescalerPickBit ? 8'h40 : 8'h80)
			+ ((s.swallowLeft != '0) ? 8'h01 : 8'h00);
	endproperty
	a_modulus: assert property (p_modulus)
		else $error("prescaler modulus wrong");

	property p_reload;
		preTick && s.progLeft == 11'h001 |=>
			s.progLeft == $past(s.progRatio)
			&& s.swallowLeft == $past(s.swallowRatio) && vcoSidePulse;
	endproperty
	a_reload: assert property (p_reload)
		else $error("feedback counters did not reload");

	property p_monitor;
		##1 dividerMonitorPin == ($past(phaseSenseSelect)
			? refSidePulse : vcoSidePulse);
	endproperty
	a_monitor: assert property (p_monitor)
		else $error("monitor pin shows the wrong divider");

	property p_lock_pulses;
		s.pfd == spd_pkg::PFD_IDLE && refFire && vcoFire |=>
			pumpUp && pumpDown ##1 !(pumpUp && pumpDown);
	endproperty
	a_lock_pulses: assert property (p_lock_pulses)
		else $error("locked edges gave no minimum-width pulses");

	property p_polarity;
		s.pfd == spd_pkg::PFD_IDLE && refFire && !vcoFire |=>
			($past(phaseSenseSelect) ? pumpUp : pumpDown) == 1'b1
			&& extPumpUpN == !pumpUp && extPumpDownN == !pumpDown;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("phase detector polarity wrong");

	property p_ref_count;
		refFire |-> s.refCnt >= s.refRatio - 14'h0001
			##1 s.refCnt == '0 && refSidePulse;
	endproperty
	a_ref_count: assert property (p_ref_count)
		else $error("reference divider fired at the wrong count");

endmodule : spd_dividers

`default_nettype wire

// ===== common/spd_pkg.sv
// Package for the serially programmed synthesizer dividers.
// Assumes a single 40 MHz system clock samples every input of the block except the asynchronous rstn.
`default_nettype none

package spd_pkg;

	// ----------------------------------------------------------------
	// Serial word layout
	// ----------------------------------------------------------------
	localparam int WORD_W = 19;
	localparam int STEER_BIT = 0;
	localparam int REF_LSB = 1;
	localparam int REF_MSB = 14;
	localparam int PICK_BIT = 15;
	localparam int SWAL_LSB = 1;
	localparam int SWAL_MSB = 7;
	localparam int PROG_LSB = 8;
	localparam int PROG_MSB = 18;

	localparam int REF_W = 14;
	localparam int SWAL_W = 7;
	localparam int PROG_W = 11;
	localparam int PRE_W = 8;

	// ----------------------------------------------------------------
	// Prescaler moduli (lower value of each pair)
	// ----------------------------------------------------------------
	localparam logic [PRE_W-1:0] PRE_MOD_WIDE = 8'h80;
	localparam logic [PRE_W-1:0] PRE_MOD_NARROW = 8'h40;

	// ----------------------------------------------------------------
	// Values held until the first load
	// ----------------------------------------------------------------
	localparam logic [REF_W-1:0] RST_REF_RATIO = 14'h0003;
	localparam logic RST_PICK = 1'h0;
	localparam logic [SWAL_W-1:0] RST_SWAL_RATIO = 7'h00;
	localparam logic [PROG_W-1:0] RST_PROG_RATIO = 11'h003;

	// ----------------------------------------------------------------
	// Phase detector states
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		PFD_IDLE = 3'b001,
		PFD_UP = 3'b010,
		PFD_DOWN = 3'b100
	} spd_pfd_t;

	// ----------------------------------------------------------------
	// Whole state of the core
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [WORD_W-1:0] shiftReg;
		logic sclkPrev;
		logic loadPrev;
		logic oscPrev;
		logic rfPrev;
		logic [REF_W-1:0] refRatio;
		logic prescalerPickBit;
		logic [SWAL_W-1:0] swallowRatio;
		logic [PROG_W-1:0] progRatio;
		logic [REF_W-1:0] refCnt;
		logic [PRE_W-1:0] preCnt;
		logic [SWAL_W-1:0] swallowLeft;
		logic [PROG_W-1:0] progLeft;
		spd_pfd_t pfd;
		logic refSidePulse;
		logic vcoSidePulse;
		logic monitor;
		logic pumpUp;
		logic pumpDown;
		logic extUpN;
		logic extDownN;
	} spd_state_t;

	localparam spd_state_t RST_STATE = '{
		shiftReg: '0,
		sclkPrev: 1'h0,
		loadPrev: 1'h0,
		oscPrev: 1'h0,
		rfPrev: 1'h0,
		refRatio: RST_REF_RATIO,
		prescalerPickBit: RST_PICK,
		swallowRatio: RST_SWAL_RATIO,
		progRatio: RST_PROG_RATIO,
		refCnt: '0,
		preCnt: '0,
		swallowLeft: RST_SWAL_RATIO,
		progLeft: RST_PROG_RATIO,
		pfd: PFD_IDLE,
		refSidePulse: 1'h0,
		vcoSidePulse: 1'h0,
		monitor: 1'h0,
		pumpUp: 1'h0,
		pumpDown: 1'h0,
		extUpN: 1'h1,
		extDownN: 1'h1
	};

	// Current prescaler modulus: one more while swallowing
	function automatic logic [PRE_W-1:0] preModulus(
		input logic pick,
		input logic swallowing
	);
		logic [PRE_W-1:0] base;
		base = pick ? PRE_MOD_NARROW : PRE_MOD_WIDE;
		return base + {{(PRE_W-1){1'b0}}, swallowing};
	endfunction : preModulus

endpackage : spd_pkg

`default_nettype wire

// ===== tb/spd_host.sv
// Host model driving the three-wire serial load port.
// Assumes sendWord is called from a process synchronous to clk.
`default_nettype none

module spd_host
(
	// System
	input wire logic clk,
	// Serial port
	output logic serialClk,
	output logic serialData,
	output logic loadStrobe
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		serialClk = 1'h0;
		serialData = 1'h0;
		loadStrobe = 1'h0;
	end

	// Extra leading bits are junk that the last 19 must push out
	task automatic sendWord(input logic [18:0] w, input int extra);
		logic b;
		b = 1'h0;
		for (int i = 18 + extra; i >= 0; i--)
		begin
			b = (i > 18) ? ~w[18] : w[i];
			@(posedge clk);
			#1 serialClk = 1'h0;
			serialData = b;
			@(posedge clk);
			#1 serialClk = 1'h1;
		end
		@(posedge clk);
		// Released line shows the inverse, not a stale bit
		#1 serialClk = 1'h0;
		serialData = ~b;
		@(posedge clk);
		#1 loadStrobe = 1'h1;
		@(posedge clk);
		#1 loadStrobe = 1'h0;
	endtask : sendWord

endmodule : spd_host

`default_nettype wire

// ===== tb/spd_dividers_bench.sv
// Bench: loads random words, toggles both oscillators, checks the
// divided pulses, monitor and pump polarity against integer counts.
// Assumes spd_host drives the serial port.
`default_nettype none

module spd_dividers_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk, rstn, refOsc, rfIn, sense, prevSense, freeze, lockMode;
	logic serialClk, serialData, loadStrobe;
	logic refP, vcoP, mon, up, dn, upN, dnN, prevUp, prevDn;
	logic [31:0] lfsr;
	logic [13:0] rr;
	logic [10:0] bb;
	logic [6:0] aa;
	logic pk;
	int num_errors, n_tests, refSince, rfSince, skipR, skipV;
	int expR, expN, tick, vcoSeen;

	spd_host host
	(
		.clk(clk),
		.serialClk(serialClk),
		.serialData(serialData),
		.loadStrobe(loadStrobe)
	);

	spd_dividers uut
	(
		.clk(clk), .rstn(rstn),
		.serialClk(serialClk), .serialData(serialData),
		.loadStrobe(loadStrobe), .refOsc(refOsc), .rfIn(rfIn),
		.phaseSenseSelect(sense), .refSidePulse(refP),
		.vcoSidePulse(vcoP), .dividerMonitorPin(mon),
		.pumpUp(up), .pumpDown(dn),
		.extPumpUpN(upN), .extPumpDownN(dnN)
	);

	always #12.5 clk = ~clk;

	// ------------------------------------------------------------
	// Compare and closing tasks
	// ------------------------------------------------------------
	task automatic chkBit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chkBit

	task automatic chkCount(input int got, input int exp);
		n_tests++;
		if (got != exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chkCount

	task automatic test_done();
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	function automatic logic [31:0] nextLfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nextLfsr

	// ------------------------------------------------------------
	// Output checks, then oscillators (ref 6 clk, rf 4 clk period)
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		if (rstn)
		begin
			chkBit(upN, ~up);
			chkBit(dnN, ~dn);
			chkBit(mon, prevSense ? refP : vcoP);
			if (refP && !vcoP && !prevUp && !prevDn)
				chkBit(prevSense ? up : dn, 1'h1);
			if (refP && vcoP && !prevUp && !prevDn)
				chkBit(up && dn, 1'h1);
			if (prevUp && prevDn)
				chkBit(up && dn, 1'h0);
			if (refP)
			begin
				if (skipR > 0)
					skipR--;
				else
					chkCount(refSince, expR);
				refSince = 0;
			end
			if (vcoP)
			begin
				if (skipV > 0)
					skipV--;
				else
					chkCount(rfSince, expN);
				rfSince = 0;
				vcoSeen++;
			end
		end
		prevUp = up;
		prevDn = dn;
		prevSense = sense;
		#1;
		tick++;
		// Frozen oscillators only ever fall, so no rise leaks into a count
		if (freeze)
		begin
			refOsc = 1'h0;
			rfIn = 1'h0;
		end
		else
		begin
			if (tick % 3 == 0 && !lockMode)
			begin
				refOsc = ~refOsc;
				refSince += refOsc;
			end
			if (tick % 2 == 0)
			begin
				rfIn = ~rfIn;
				rfSince += rfIn;
				// Same waveform on both inputs lets the two dividers coincide
				if (lockMode)
				begin
					refOsc = rfIn;
					refSince += refOsc;
				end
			end
		end
	end

	task automatic waitVco();
		vcoSeen = 0;
		for (int i = 0; i < 30000 && vcoSeen < 5; i++)
			@(posedge clk);
	endtask : waitVco

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'h0;
		rstn = 1'h0;
		refOsc = 1'h0;
		rfIn = 1'h0;
		sense = 1'h1;
		freeze = 1'h0;
		lockMode = 1'h0;
		lfsr = 32'h68dc8e42;
		expR = 3;
		expN = 384;
		skipR = 1;
		skipV = 1;
		repeat (5) @(posedge clk);
		#1 rstn = 1'h1;
		waitVco();
		for (int r = 0; r < 4; r++)
		begin
			lfsr = nextLfsr(lfsr);
			rr = 14'h0003 + lfsr[4:0];
			pk = lfsr[5];
			bb = 11'h003 + lfsr[6];
			aa = (r == 3) ? bb[6:0] : lfsr[8:7];
			#1 sense = r[0];
			host.sendWord({lfsr[12:10], pk, rr, 1'h1}, r % 2);
			expR = rr;
			skipR = 2;
			skipV = 1000;
			host.sendWord({bb, aa, 1'h0}, 0);
			expN = (pk ? 64 : 128) * bb + aa;
			skipV = 2;
			waitVco();
		end
		// Coincident edges need both dividers restarted from zero with
		// equal ratios, so both oscillators stop across a second reset
		freeze = 1'h1;
		#1 rstn = 1'h0;
		sense = 1'h1;
		refSince = 0;
		rfSince = 0;
		expR = 384;
		expN = 384;
		skipR = 0;
		skipV = 0;
		repeat (5) @(posedge clk);
		#1 rstn = 1'h1;
		host.sendWord({4'h0, 14'h0180, 1'h1}, 0);
		@(posedge clk);
		freeze = 1'h0;
		lockMode = 1'h1;
		waitVco();
		test_done();
	end

	initial
	begin
		repeat (90000) @(posedge clk);
		num_errors++;
		test_done();
	end

endmodule : spd_dividers_bench

`default_nettype wire
